// ===== src/usart_sync_slave_rx_map.vh
// Purpose: Register map, field positions and reset values of the receiver
// Assumes: word-addressed slave; register index equals printed offset
// Notes:   byte address of a register is four times its index
`ifndef USART_SYNC_SLAVE_RX_MAP_VH
`define USART_SYNC_SLAVE_RX_MAP_VH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define IDX_IRQ_FLAGS     8'h0C
`define IDX_RX_STAT_CTRL  8'h18
`define IDX_RX_BUFFER     8'h1A
`define IDX_IRQ_ENABLES   8'h8C
`define IDX_TX_STAT_CTRL  8'h98
`define IDX_BAUD_DIVISOR  8'h99
`define IDX_EVT_STATUS    8'hA0
`define IDX_EVT_CLEAR     8'hA1
`define IDX_EVT_ENABLE    8'hA2

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RCS_SERIAL_EN     7
`define RCS_NINE_BIT      6
`define RCS_SINGLE_RX     5
`define RCS_CONT_RX       4
`define RCS_ADDR_DET      3
`define RCS_FRAME_ERR     2
`define RCS_OVERRUN       1
`define RCS_NINTH_BIT     0
`define TXS_CLK_SRC       7
`define TXS_SYNC_MODE     4
`define TXS_SHIFT_EMPTY   1
`define IRQ_RX_FLAG       5
`define EVT_WORD          0
`define EVT_OVERRUN       1
`define EVT_DISCARD       2

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define RST_RX_CTRL       5'h00
`define RST_IRQ_ENABLES   8'h00
`define RST_TX_STAT_CTRL  8'h02
`define RST_BAUD_DIVISOR  8'h00
`define RST_RX_BUFFER     8'h00
`define TX_WRITE_MASK     8'hF5
`define WORD_BITS_8       4'h8
`define WORD_BITS_9       4'h9
`define IRQ_VECTOR        16'h0004
`define EVT_WIDTH         3

`endif

// ===== src/usart_sync_slave_receiver.v
// Purpose: Receive path of a serial port in synchronous slave mode
// Assumes: shift clock and data come from an external master, async to core
// Notes:   registers reached over Avalon-MM with one wait cycle per access
// Notes on behaviour
// - Slave reception works like master reception; only sleep behaviour differs.
// - Single-word receive enable is ignored in slave mode.
// - With continuous receive set, words keep shifting in during sleep.
// - A complete word moves from shift register into receive buffer.
// - Receive interrupt enabled and word done during sleep wakes the device.
// - With global interrupts enabled the wake branches to vector 0004h.
// - Slave mode when sync and port enable set and clock source clear.
// - Nine-bit select makes words nine bits long.
// - Receive flag set on completion; interrupt only if its enable set.
// - Status bit 0 ninth bit, bit 1 overrun, bit 2 framing error.
// - Reading receive buffer returns the eight data bits.
// - Clearing continuous receive clears pending receive errors.
// - Address detect drops nine-bit words with bit 8 zero, keeps bit 8 one.
`timescale 1ns/1ps
`include "usart_sync_slave_rx_map.vh"

module usart_sync_slave_receiver (
   // Core clock and reset
   input  wire        i_core_clk,
   input  wire        i_srst,
   // Avalon-MM slave
   input  wire [7:0]  i_avs_address,
   input  wire        i_avs_read,
   input  wire        i_avs_write,
   input  wire [31:0] i_avs_writedata,
   output wire [31:0] o_avs_readdata,
   output wire        o_avs_waitrequest,
   // Serial link from external master
   input  wire        i_shift_clk,
   input  wire        i_shift_data,
   // Core power and interrupt context
   input  wire        i_sleep,
   input  wire        i_global_irq_enable,
   // Interrupt and wake outputs
   output wire        o_irq,
   output wire        o_rx_irq_req,
   output wire        o_wake,
   output wire        o_vector_req,
   output wire [15:0] o_vector_addr
);

   // ---------------------------------------------------------------------
   // Bus handshake
   // ---------------------------------------------------------------------
   // Address match used by the buffer read and event clear paths
   function reg_hit;
      input [7:0] addr;
      input [7:0] idx;
      begin
         reg_hit = (addr == idx);
      end
   endfunction

   reg         wait_reg;
   reg  [31:0] rdata_reg;
   wire        req;
   wire        take;
   wire        wr_take;
   wire        rd_take;
   wire        buf_read;

   // A request is taken only in the cycle after its wait state
   assign req      = i_avs_read | i_avs_write;
   assign take     = req & ~wait_reg;
   assign wr_take  = take & i_avs_write;
   assign rd_take  = take & i_avs_read;
   // Completed read of the buffer empties it
   assign buf_read = rd_take & reg_hit(i_avs_address, `IDX_RX_BUFFER);

   // ---------------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------------
   reg  [4:0]  rx_ctrl_reg;    // Port enable, nine bit, single, continuous, addr
   reg         overrun_reg;
   reg         ninth_bit_reg;
   reg  [7:0]  rx_buffer_reg;
   reg         rx_flag_reg;
   reg  [7:0]  irq_en_reg;
   reg  [7:0]  tx_ctrl_reg;
   reg  [7:0]  baud_reg;
   reg  [2:0]  evt_stat_reg;
   reg  [2:0]  evt_en_reg;

   wire        serial_en;
   wire        nine_bit;
   wire        cont_rx;
   wire        addr_det;
   wire        slave_mode;
   wire        rx_run;
   wire        frame_err;

   // Control fields are stored from the address detect bit upward
   localparam CTRL_BASE = `RCS_ADDR_DET;

   assign serial_en = rx_ctrl_reg[`RCS_SERIAL_EN - CTRL_BASE];
   assign nine_bit  = rx_ctrl_reg[`RCS_NINE_BIT - CTRL_BASE];
   assign cont_rx   = rx_ctrl_reg[`RCS_CONT_RX - CTRL_BASE];
   assign addr_det  = rx_ctrl_reg[`RCS_ADDR_DET - CTRL_BASE];
   // No start or stop bits in synchronous mode, so no framing error
   assign frame_err = 1'b0;

   // Slave when sync mode and port enabled with external clock
   assign slave_mode = tx_ctrl_reg[`TXS_SYNC_MODE] & serial_en
                     & ~tx_ctrl_reg[`TXS_CLK_SRC];
   // Single-word enable takes no part in running the receiver
   assign rx_run = slave_mode & cont_rx & ~overrun_reg;

   // ---------------------------------------------------------------------
   // Link synchronisers
   // ---------------------------------------------------------------------
   reg         sclk_s1_reg;
   reg         sclk_s2_reg;
   reg         sclk_s3_reg;
   reg         sdat_s1_reg;
   reg         sdat_s2_reg;
   wire        sample_edge;

   // Two flops per pin, a third only for edge finding
   always @(posedge i_core_clk) begin
      sclk_s1_reg <= i_shift_clk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      sdat_s1_reg <= i_shift_data;
      sdat_s2_reg <= sdat_s1_reg;
   end

   // Data is taken at the falling edge of the master's clock
   assign sample_edge = sclk_s3_reg & ~sclk_s2_reg;

   // ---------------------------------------------------------------------
   // Shift register and word completion
   // ---------------------------------------------------------------------
   reg  [8:0]  shift_reg;
   reg  [3:0]  bit_cnt_reg;
   wire [3:0]  word_len;
   wire        bit_in;
   wire        word_done;
   wire [7:0]  word_data;
   wire        word_b8;
   wire        word_keep;
   wire        word_load;
   wire        word_ovr;

   assign word_len  = nine_bit ? `WORD_BITS_9 : `WORD_BITS_8;
   assign bit_in    = rx_run & sample_edge;
   assign word_done = bit_in & (bit_cnt_reg == word_len - 4'h1);

   // LSB first; a nine-bit word has bit 8 on the line and bits 7..0 shifted in,
   // an eight-bit word has bit 7 on the line and sits one place higher
   assign word_data = nine_bit ? shift_reg[8:1]
                               : {sdat_s2_reg, shift_reg[8:2]};
   assign word_b8   = nine_bit ? sdat_s2_reg : 1'b0;

   // Address detect drops data words in nine-bit mode
   assign word_keep = ~(addr_det & nine_bit & ~word_b8);
   // A buffer read in the completing cycle frees the buffer, so the load wins
   // over the read; only a word meeting a still unread buffer is an overrun
   assign word_load = word_done & word_keep & (~rx_flag_reg | buf_read);
   assign word_ovr  = word_done & word_keep & rx_flag_reg & ~buf_read;

   // Bit counter and shifter run whether or not the core sleeps
   always @(posedge i_core_clk) begin
      if (i_srst || !rx_run) begin
         shift_reg   <= 9'h000;
         bit_cnt_reg <= 4'h0;
      end else if (bit_in) begin
         shift_reg <= {sdat_s2_reg, shift_reg[8:1]};
         if (word_done) begin
            bit_cnt_reg <= 4'h0;
         end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         end
      end
   end

   // ---------------------------------------------------------------------
   // Receive buffer, flag and error bits
   // ---------------------------------------------------------------------
   // Buffer loads on completion; a read empties it, a new word wins
   always @(posedge i_core_clk) begin
      if (i_srst) begin
         rx_buffer_reg <= `RST_RX_BUFFER;
         ninth_bit_reg <= 1'b0;
         rx_flag_reg   <= 1'b0;
      end else if (word_load) begin
         rx_buffer_reg <= word_data;
         ninth_bit_reg <= word_b8;
         rx_flag_reg   <= 1'b1;
      end else if (buf_read) begin
         rx_flag_reg   <= 1'b0;
      end
   end

   // Overrun holds until continuous receive is cleared
   always @(posedge i_core_clk) begin
      if (i_srst) begin
         overrun_reg <= 1'b0;
      end else if (word_ovr) begin
         overrun_reg <= 1'b1;
      end else if (!cont_rx) begin
         overrun_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------------
   // Software registers
   // ---------------------------------------------------------------------
   wire [7:0]  wbyte;
   assign wbyte = i_avs_writedata[7:0];

   always @(posedge i_core_clk) begin
      if (i_srst) begin
         rx_ctrl_reg <= `RST_RX_CTRL;
         irq_en_reg  <= `RST_IRQ_ENABLES;
         tx_ctrl_reg <= `RST_TX_STAT_CTRL;
         baud_reg    <= `RST_BAUD_DIVISOR;
         evt_en_reg  <= 3'h0;
      end else if (wr_take) begin
         case (i_avs_address)
            `IDX_RX_STAT_CTRL: begin
               rx_ctrl_reg <= wbyte[7:CTRL_BASE];
            end
            `IDX_IRQ_ENABLES: begin
               irq_en_reg <= wbyte;
            end
            `IDX_TX_STAT_CTRL: begin
               tx_ctrl_reg <= (wbyte & `TX_WRITE_MASK) | `RST_TX_STAT_CTRL;
            end
            `IDX_BAUD_DIVISOR: begin
               baud_reg <= wbyte;
            end
            `IDX_EVT_ENABLE: begin
               evt_en_reg <= wbyte[2:0];
            end
            default: begin
               rx_ctrl_reg <= rx_ctrl_reg;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------------
   // Event status, set wins over clear
   // ---------------------------------------------------------------------
   wire [2:0]  evt_set;
   wire [2:0]  evt_clr;
   wire [2:0]  evt_stat_next;
   genvar      gi;

   assign evt_set = {word_done & ~word_keep, word_ovr, word_load};
   assign evt_clr = (wr_take && reg_hit(i_avs_address, `IDX_EVT_CLEAR))
                    ? wbyte[2:0] : 3'h0;

   // Each sticky bit on its own; an event in the clearing cycle keeps it set
   generate
      for (gi = 0; gi < `EVT_WIDTH; gi = gi + 1) begin : g_evt
         assign evt_stat_next[gi] = evt_set[gi] | (evt_stat_reg[gi] & ~evt_clr[gi]);
      end
   endgenerate

   always @(posedge i_core_clk) begin
      if (i_srst) begin
         evt_stat_reg <= 3'h0;
      end else begin
         evt_stat_reg <= evt_stat_next;
      end
   end

   // ---------------------------------------------------------------------
   // Read multiplexer
   // ---------------------------------------------------------------------
   reg  [7:0]  rmux;
   always @* begin
      case (i_avs_address)
         `IDX_IRQ_FLAGS:    rmux = {2'b00, rx_flag_reg, 5'h00};
         `IDX_RX_STAT_CTRL: rmux = {rx_ctrl_reg, frame_err, overrun_reg,
                                    ninth_bit_reg};
         `IDX_RX_BUFFER:    rmux = rx_buffer_reg;
         `IDX_IRQ_ENABLES:  rmux = irq_en_reg;
         `IDX_TX_STAT_CTRL: rmux = tx_ctrl_reg;
         `IDX_BAUD_DIVISOR: rmux = baud_reg;
         `IDX_EVT_STATUS:   rmux = {5'h00, evt_stat_reg};
         `IDX_EVT_ENABLE:   rmux = {5'h00, evt_en_reg};
         default:           rmux = 8'h00;
      endcase
   end

   // One wait cycle, then the access completes
   always @(posedge i_core_clk) begin
      if (i_srst) begin
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h00000000;
      end else begin
         wait_reg <= ~(req & wait_reg);
         if (req && wait_reg) begin
            rdata_reg <= {24'h000000, rmux};
         end
      end
   end

   // ---------------------------------------------------------------------
   // Interrupt, wake and vector outputs
   // ---------------------------------------------------------------------
   reg         irq_reg;
   reg         rx_req_reg;
   reg         wake_reg;
   reg         vec_reg;
   reg  [15:0] vec_addr_reg;
   wire        rx_int;

   // Request only while flag and its enable are both set
   assign rx_int = rx_flag_reg & irq_en_reg[`IRQ_RX_FLAG];

   always @(posedge i_core_clk) begin
      if (i_srst) begin
         irq_reg      <= 1'b0;
         rx_req_reg   <= 1'b0;
         wake_reg     <= 1'b0;
         vec_reg      <= 1'b0;
         vec_addr_reg <= 16'h0000;
      end else begin
         irq_reg    <= |(evt_stat_reg & evt_en_reg);
         rx_req_reg <= rx_int;
         wake_reg   <= rx_int & i_sleep;
         vec_reg    <= rx_int & i_global_irq_enable;
         vec_addr_reg <= (rx_int & i_global_irq_enable)
                         ? `IRQ_VECTOR : 16'h0000;
      end
   end

   assign o_avs_readdata    = rdata_reg;
   assign o_avs_waitrequest = wait_reg;
   assign o_irq             = irq_reg;
   assign o_rx_irq_req      = rx_req_reg;
   assign o_wake            = wake_reg;
   assign o_vector_req      = vec_reg;
   assign o_vector_addr     = vec_addr_reg;

endmodule

// ===== tb/serial_master_model.sv
// Purpose: External master driving shift clock and data
// Assumes: clock idles high, bits taken on its falling edge
// Notes:   data line shows the inverse of the last bit when idle
`timescale 1ns/1ps
module serial_master_model (
   // Serial link
   output logic o_sclk,
   output logic o_sdata
);
   // Idle levels
   initial begin
      o_sclk = 1'b1;
      o_sdata = 1'b0;
   end

   // One word, LSB first, 125 ns per bit, data set while clock high
   task automatic send(input logic [8:0] w, input int n);
      #3;
      for (int k = 0; k < n; k++) begin
         o_sdata = w[k];
         #62.5 o_sclk = 1'b0;
         #62.5 o_sclk = 1'b1;
      end
      o_sdata = ~w[n-1];
   endtask
endmodule

// ===== tb/usart_rx_chk.sv
// Purpose: Port checker for the receiver
// Assumes: one clock domain, synchronous reset
// Notes:   bound to the receiver below
`timescale 1ns/1ps
module usart_rx_chk (
   // Clock and reset
   input wire        i_core_clk,
   input wire        i_srst,
   // Register bus
   input wire [7:0]  i_avs_address,
   input wire        i_avs_read,
   input wire        i_avs_write,
   input wire [31:0] o_avs_readdata,
   input wire        o_avs_waitrequest,
   // Context and interrupts
   input wire        i_sleep,
   input wire        i_global_irq_enable,
   input wire        o_rx_irq_req,
   input wire        o_wake,
   input wire        o_vector_req,
   input wire [15:0] o_vector_addr
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);

   // Request waiting, and a completed read of the buffer
   sequence req_s;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   sequence buf_read_s;
      i_avs_read && !o_avs_waitrequest && i_avs_address == 8'h1A;
   endsequence

   one_wait_a: assert property (req_s |=> !o_avs_waitrequest)
      else $error("bus answer late");
   wait_back_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("wait not restored");
   upper_zero_a: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   data_hold_a: assert property (!i_avs_read && !i_avs_write |=> $stable(o_avs_readdata))
      else $error("read data changed while idle");
   flag_clear_a: assert property (buf_read_s |=> ##1 !o_rx_irq_req)
      else $error("receive request kept after buffer read");
   wake_gate_a: assert property (o_wake == (o_rx_irq_req && $past(i_sleep)))
      else $error("wake mismatch");
   vector_gate_a: assert property (o_vector_req == (o_rx_irq_req && $past(i_global_irq_enable)))
      else $error("vector request mismatch");
   vector_addr_a: assert property (o_vector_addr == (o_vector_req ? 16'h0004 : 16'h0000))
      else $error("vector address wrong");
endmodule

bind usart_sync_slave_receiver usart_rx_chk chk_i (
   .i_core_clk(i_core_clk), .i_srst(i_srst), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .i_sleep(i_sleep),
   .i_global_irq_enable(i_global_irq_enable), .o_rx_irq_req(o_rx_irq_req),
   .o_wake(o_wake), .o_vector_req(o_vector_req), .o_vector_addr(o_vector_addr));

// ===== tb/usart_sync_slave_receiver_bench.sv
// Purpose: Self-checking bench of the receiver
// Assumes: no fixed wait count; each bus access waits for waitrequest low
// Notes:   serial words come from the master model
`timescale 1ns/1ps
module usart_sync_slave_receiver_bench;
   logic        i_core_clk, i_srst, i_avs_read, i_avs_write;
   logic [7:0]  i_avs_address;
   logic [31:0] i_avs_writedata, o_avs_readdata, rd;
   logic        o_avs_waitrequest, i_shift_clk, i_shift_data, i_sleep;
   logic        i_global_irq_enable, o_irq, o_rx_irq_req, o_wake, o_vector_req;
   logic [15:0] o_vector_addr;
   int          err_count = 0;
   int          n_compared = 0;

   usart_sync_slave_receiver usart_sync_slave_receiver_i (
      .i_core_clk(i_core_clk), .i_srst(i_srst), .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
      .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
      .i_shift_clk(i_shift_clk), .i_shift_data(i_shift_data), .i_sleep(i_sleep),
      .i_global_irq_enable(i_global_irq_enable), .o_irq(o_irq), .o_rx_irq_req(o_rx_irq_req),
      .o_wake(o_wake), .o_vector_req(o_vector_req), .o_vector_addr(o_vector_addr));
   serial_master_model serial_master_model_i (.o_sclk(i_shift_clk), .o_sdata(i_shift_data));

   // Comparison and verdict
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // One bus access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      i_avs_address <= a;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      i_avs_writedata <= {24'h000000, d};
      // No cycle count assumed; only the watchdog ends a hung wait
      do begin
         @(posedge i_core_clk);
      end while (o_avs_waitrequest !== 1'b0);
      rd = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
      @(posedge i_core_clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(rd, {24'h000000, e});
   endtask
   task automatic settle;
      repeat (20) @(posedge i_core_clk);
      #1;
   endtask

   // Reset values, unmapped and read-only places
   task automatic t_regs;
      logic [7:0] a [7] = '{8'h0C, 8'h18, 8'h1A, 8'h8C, 8'h98, 8'h99, 8'h50};
      logic [7:0] e [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
      for (int k = 0; k < 7; k++) rchk(a[k], e[k]);
      bus(1'b1, 8'h1A, 8'h5A);
      rchk(8'h1A, 8'h00);
      $display("t_regs done");
   endtask
   // Plain word with single-word bit set, event interrupt
   task automatic t_word;
      bus(1'b1, 8'h98, 8'h10);
      bus(1'b1, 8'h8C, 8'h20);
      bus(1'b1, 8'hA2, 8'h01);
      bus(1'b1, 8'h18, 8'hB0);
      serial_master_model_i.send(9'h0A5, 8);
      settle;
      chk(o_rx_irq_req, 1);
      chk(o_irq, 1);
      rchk(8'h0C, 8'h20);
      rchk(8'h1A, 8'hA5);
      rchk(8'h0C, 8'h00);
      bus(1'b1, 8'hA1, 8'h07);
      settle;
      chk(o_irq, 0);
      $display("t_word done");
   endtask
   // Two words unread, then recovery by dropping continuous enable
   task automatic t_over;
      bus(1'b1, 8'h18, 8'h90);
      serial_master_model_i.send(9'h011, 8);
      serial_master_model_i.send(9'h022, 8);
      settle;
      rchk(8'h18, 8'h92);
      rchk(8'h1A, 8'h11);
      bus(1'b1, 8'h18, 8'h80);
      rchk(8'h18, 8'h80);
      bus(1'b1, 8'h18, 8'h90);
      serial_master_model_i.send(9'h033, 8);
      settle;
      rchk(8'h1A, 8'h33);
      $display("t_over done");
   endtask
   // Nine-bit words and address detect
   task automatic t_nine;
      bus(1'b1, 8'h18, 8'hD0);
      serial_master_model_i.send(9'h1C3, 9);
      settle;
      rchk(8'h18, 8'hD1);
      rchk(8'h1A, 8'hC3);
      bus(1'b1, 8'hA1, 8'h07);
      bus(1'b1, 8'h18, 8'hD8);
      serial_master_model_i.send(9'h055, 9);
      settle;
      chk(o_rx_irq_req, 0);
      rchk(8'hA0, 8'h04);
      serial_master_model_i.send(9'h1AA, 9);
      settle;
      rchk(8'h1A, 8'hAA);
      $display("t_nine done");
   endtask
   // Word during sleep wakes and vectors
   task automatic t_sleep;
      bus(1'b1, 8'h18, 8'h90);
      i_sleep <= 1'b1;
      i_global_irq_enable <= 1'b1;
      serial_master_model_i.send(9'h03C, 8);
      settle;
      chk(o_wake, 1);
      chk(o_vector_req, 1);
      chk(o_vector_addr, 32'h0004);
      bus(1'b1, 8'h8C, 8'h00);
      settle;
      chk(o_rx_irq_req, 0);
      i_sleep <= 1'b0;
      rchk(8'h1A, 8'h3C);
      $display("t_sleep done");
   endtask
   // Clock source set means not slave: words ignored
   task automatic t_mode;
      bus(1'b1, 8'h98, 8'h90);
      serial_master_model_i.send(9'h077, 8);
      settle;
      rchk(8'h0C, 8'h00);
      bus(1'b1, 8'h98, 8'h10);
      serial_master_model_i.send(9'h066, 8);
      settle;
      rchk(8'h1A, 8'h66);
      $display("t_mode done");
   endtask

   // Clock
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   // Main sequence
   initial begin
      i_srst = 1'b1;
      i_avs_address = 8'h00;
      i_avs_read = 1'b0;
      i_avs_write = 1'b0;
      i_avs_writedata = 32'h00000000;
      i_sleep = 1'b0;
      i_global_irq_enable = 1'b0;
      repeat (12) @(posedge i_core_clk);
      i_srst <= 1'b0;
      @(posedge i_core_clk);
      t_regs;
      t_word;
      t_over;
      t_nine;
      t_sleep;
      t_mode;
      complete_run;
   end
   // Watchdog
   initial begin
      #200000;
      err_count++;
      complete_run;
   end
endmodule
